// >>> daio_pkg.sv
package daio_pkg;
   localparam int unsigned  ADDR_W            = 12;
   localparam int unsigned  DATA_W            = 32;
   localparam int unsigned  REG_W             = 16;
   // Printed offsets are not all multiples of four: they are word indices
   localparam logic [9:0]   IDX_OUT_CTRL      = 10'h001;
   localparam logic [9:0]   IDX_IN_CTRL       = 10'h002;
   localparam logic [9:0]   IDX_PWR_CLK       = 10'h004;
   localparam logic [9:0]   IDX_PATH_STATUS   = 10'h008;
   localparam int unsigned  OUT_MUTE_BIT      = 8;
   localparam int unsigned  OUT_PWR_BIT       = 7;
   localparam int unsigned  OUT_SRC_HI        = 5;
   localparam int unsigned  OUT_SRC_LO        = 4;
   localparam int unsigned  FMT_HI            = 2;
   localparam int unsigned  IN_PWR_BIT        = 7;
   localparam int unsigned  DAC_PWR_BIT       = 15;
   localparam int unsigned  ADCL_PWR_BIT      = 10;
   localparam int unsigned  ADCR_PWR_BIT      = 9;
   localparam int unsigned  ADC_BIAS_BIT      = 8;
   localparam int unsigned  DAC_CLK_BIT       = 7;
   localparam int unsigned  DAC_AUTO_BIT      = 6;
   localparam int unsigned  DEC_CLK_BIT       = 2;
   localparam int unsigned  INT_CLK_BIT       = 0;
   localparam logic [15:0]  OUT_CTRL_MASK     = 16'h01B7;
   localparam logic [15:0]  IN_CTRL_MASK      = 16'h0087;
   localparam logic [15:0]  PWR_CLK_MASK      = 16'h87C5;
   localparam logic [15:0]  OUT_CTRL_RESET    = 16'h00A0;
   localparam logic [15:0]  IN_CTRL_RESET     = 16'h0080;
   localparam logic [15:0]  PWR_CLK_RESET     = 16'h8705;
   localparam logic [1:0]   RESP_OKAY         = 2'h0;
   localparam logic [1:0]   RESP_SLVERR       = 2'h2;

   typedef enum logic [1:0] {
      SRC_ADC    = 2'h0,
      SRC_SERIAL = 2'h1,
      SRC_IEC    = 2'h2,
      SRC_MIXER  = 2'h3
   } daio_src_t;

   typedef enum logic [2:0] {
      FMT_I2S    = 3'h0,
      FMT_LSB16  = 3'h1,
      FMT_LSB18  = 3'h2,
      FMT_LSB20  = 3'h3,
      FMT_LSB24  = 3'h4,
      FMT_MSB    = 3'h5
   } daio_fmt_t;

   localparam daio_src_t    DEFAULT_SRC       = SRC_IEC;
   localparam daio_fmt_t    DEFAULT_FMT       = FMT_I2S;
endpackage : daio_pkg

// >>> daio_regif.sv
`timescale 1ns/1ps
`default_nettype none
interface daio_regif;
   logic        wrEn;
   logic        rdEn;
   logic [9:0]  index;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;
   logic [31:0] rdData;
   logic        hit;
   modport slave  (input wrEn, rdEn, index, wrData, wrStrb,
                   output rdData, hit);
   modport master (output wrEn, rdEn, index, wrData, wrStrb,
                   input rdData, hit);
endinterface : daio_regif
`default_nettype wire

// >>> daio_axil.sv
`timescale 1ns/1ps
`default_nettype none
module daio_axil
   import daio_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [DATA_W-1:0]        rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   daio_regif.master                rif
);
   logic                awHave_reg, awHave_next;
   logic                wHave_reg, wHave_next;
   logic [9:0]          awIdx_reg, awIdx_next;
   logic [31:0]         wData_reg, wData_next;
   logic [3:0]          wStrb_reg, wStrb_next;
   logic                bValid_reg, bValid_next;
   logic [1:0]          bResp_reg, bResp_next;
   logic                rValid_reg, rValid_next;
   logic [1:0]          rResp_reg, rResp_next;
   logic [31:0]         rData_reg, rData_next;
   logic                doWrite;

   assign awready = !awHave_reg && !bValid_reg;
   assign wready  = !wHave_reg && !bValid_reg;
   assign arready = !rValid_reg;
   assign doWrite = awHave_reg && wHave_reg && !bValid_reg;
   assign bvalid  = bValid_reg;
   assign bresp   = bResp_reg;
   assign rvalid  = rValid_reg;
   assign rresp   = rResp_reg;
   assign rdata   = rData_reg;
   // A read owns the index port this cycle, so the write must wait
   assign rif.wrEn   = doWrite && !rif.rdEn;
   assign rif.rdEn   = arvalid && arready;
   assign rif.index  = rif.rdEn ? araddr[11:2] : awIdx_reg;
   assign rif.wrData = wData_reg;
   assign rif.wrStrb = wStrb_reg;

   always_comb begin
      awHave_next = awHave_reg;
      wHave_next  = wHave_reg;
      awIdx_next  = awIdx_reg;
      wData_next  = wData_reg;
      wStrb_next  = wStrb_reg;
      bValid_next = bValid_reg;
      bResp_next  = bResp_reg;
      rValid_next = rValid_reg;
      rResp_next  = rResp_reg;
      rData_next  = rData_reg;
      if (awvalid && awready) begin
         awHave_next = 1'b1;
         awIdx_next  = awaddr[11:2];
      end
      if (wvalid && wready) begin
         wHave_next = 1'b1;
         wData_next = wdata;
         wStrb_next = wstrb;
      end
      // Write and read share the index port; a read in the same cycle
      // defers the write by one cycle
      if (doWrite && !rif.rdEn) begin
         awHave_next = 1'b0;
         wHave_next  = 1'b0;
         bValid_next = 1'b1;
         bResp_next  = rif.hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bValid_reg && bready) begin
         bValid_next = 1'b0;
      end
      if (rif.rdEn) begin
         rValid_next = 1'b1;
         rData_next  = rif.rdData;
         rResp_next  = rif.hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_reg && rready) begin
         rValid_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         awHave_reg <= 1'b0;
         wHave_reg  <= 1'b0;
         awIdx_reg  <= 10'h000;
         wData_reg  <= 32'h00000000;
         wStrb_reg  <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg  <= 2'h0;
         rValid_reg <= 1'b0;
         rResp_reg  <= 2'h0;
         rData_reg  <= 32'h00000000;
      end else begin
         awHave_reg <= awHave_next;
         wHave_reg  <= wHave_next;
         awIdx_reg  <= awIdx_next;
         wData_reg  <= wData_next;
         wStrb_reg  <= wStrb_next;
         bValid_reg <= bValid_next;
         bResp_reg  <= bResp_next;
         rValid_reg <= rValid_next;
         rResp_reg  <= rResp_next;
         rData_reg  <= rData_next;
      end
   end
endmodule : daio_axil
`default_nettype wire

// >>> daio_regs.sv
// Behaviour
// - Output mute bit mutes digital audio output
// - Output power bit zero powers output down
// - Registers stay on own clock, always reachable
// - Two-bit selector picks digital output source
// - Invalid selected source falls back to default
// - Three-bit field sets serial output format
// - Unused output format codes mean default
// - Input power bit zero powers input down
// - Three-bit field sets serial input format
// - Unused input format codes mean default
// - Output control resets to bits 7, 5
// - Input control resets to bit 7
// - Power register resets to bits 15,10,9,8,2,0
// - Bit 15 powers DAC, ignoring mute
// - ADC power needs bias plus channel bit
// - DAC clock enable, auto gate on PLL unlock
// - Bits 2, 0 gate decimator, interpolator clocks
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module daio_regs
   import daio_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic [ADDR_W-1:0]   awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   input  wire logic [ADDR_W-1:0]   araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [DATA_W-1:0]        rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   input  wire logic [3:0]          sourceValid,
   input  wire logic                pllLocked,
   output logic                     outputMute,
   output logic                     outputPowerOn,
   output daio_pkg::daio_src_t      outputSource,
   output daio_pkg::daio_fmt_t      outputWordFormat,
   output logic                     inputPowerOn,
   output daio_pkg::daio_fmt_t      inputWordFormat,
   output logic                     dacPowerOn,
   output logic                     leftAdcPowerOn,
   output logic                     rightAdcPowerOn,
   output logic                     adcBiasPowerOn,
   output logic                     dacClockEnable,
   output logic                     interpolatorMute,
   output logic                     decimatorClockEnable,
   output logic                     interpolatorClockEnable
);
   daio_regif rif ();

   logic [15:0]         outCtrl_reg, outCtrl_next;
   logic [15:0]         inCtrl_reg, inCtrl_next;
   logic [15:0]         pwrClk_reg, pwrClk_next;
   logic                outputMute_reg, outputMute_next;
   logic                outputPowerOn_reg, outputPowerOn_next;
   daio_src_t           outputSource_reg, outputSource_next;
   daio_fmt_t           outputFmt_reg, outputFmt_next;
   logic                inputPowerOn_reg, inputPowerOn_next;
   daio_fmt_t           inputFmt_reg, inputFmt_next;
   logic                dacPower_reg, dacPower_next;
   logic                adcL_reg, adcL_next;
   logic                adcR_reg, adcR_next;
   logic                adcBias_reg, adcBias_next;
   logic                dacClk_reg, dacClk_next;
   logic                intMute_reg, intMute_next;
   logic                decClk_reg, decClk_next;
   logic                intClk_reg, intClk_next;
   logic                autoGate;
   logic [1:0]          selSrc;

   // Bus slave runs on clk alone, never on a gated datapath clock
   daio_axil u_axil (
      .clk     (clk),
      .nrst    (nrst),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .rif     (rif.master)
   );

   function automatic daio_fmt_t decodeFmt(input logic [2:0] code);
      if (code > 3'h5) begin
         decodeFmt = DEFAULT_FMT;
      end else begin
         decodeFmt = daio_fmt_t'(code);
      end
   endfunction : decodeFmt

   function automatic logic [15:0] mergeWord(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb,
                                             input logic [15:0] mask);
      logic [15:0] merged;
      merged = old;
      if (strb[0]) begin
         merged[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merged[15:8] = data[15:8];
      end
      // Reserved bits are not stored and read as zero
      mergeWord = merged & mask;
   endfunction : mergeWord

   always_comb begin
      rif.hit    = 1'b1;
      rif.rdData = 32'h00000000;
      case (rif.index)
         IDX_OUT_CTRL:    rif.rdData = {16'h0000, outCtrl_reg};
         IDX_IN_CTRL:     rif.rdData = {16'h0000, inCtrl_reg};
         IDX_PWR_CLK:     rif.rdData = {16'h0000, pwrClk_reg};
         IDX_PATH_STATUS: rif.rdData = {16'h0000, 6'h00,
                                        outputSource_reg, autoGate,
                                        dacClk_reg, intMute_reg,
                                        pllLocked, sourceValid};
         default:         rif.hit = 1'b0;
      endcase
   end

   always_comb begin
      outCtrl_next = outCtrl_reg;
      inCtrl_next  = inCtrl_reg;
      pwrClk_next  = pwrClk_reg;
      if (rif.wrEn) begin
         case (rif.index)
            IDX_OUT_CTRL: outCtrl_next = mergeWord(outCtrl_reg, rif.wrData,
                                                   rif.wrStrb, OUT_CTRL_MASK);
            IDX_IN_CTRL:  inCtrl_next = mergeWord(inCtrl_reg, rif.wrData,
                                                  rif.wrStrb, IN_CTRL_MASK);
            IDX_PWR_CLK:  pwrClk_next = mergeWord(pwrClk_reg, rif.wrData,
                                                  rif.wrStrb, PWR_CLK_MASK);
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         outCtrl_reg <= OUT_CTRL_RESET;
         inCtrl_reg  <= IN_CTRL_RESET;
         pwrClk_reg  <= PWR_CLK_RESET;
      end else begin
         outCtrl_reg <= outCtrl_next;
         inCtrl_reg  <= inCtrl_next;
         pwrClk_reg  <= pwrClk_next;
      end
   end

   assign selSrc   = outCtrl_reg[OUT_SRC_HI:OUT_SRC_LO];
   assign autoGate = pwrClk_reg[DAC_AUTO_BIT] && !pllLocked;

   always_comb begin
      outputMute_next    = outCtrl_reg[OUT_MUTE_BIT];
      outputPowerOn_next = outCtrl_reg[OUT_PWR_BIT];
      outputSource_next  = daio_src_t'(selSrc);
      if (!sourceValid[selSrc]) begin
         outputSource_next = DEFAULT_SRC;
      end
      outputFmt_next    = decodeFmt(outCtrl_reg[FMT_HI:0]);
      inputPowerOn_next = inCtrl_reg[IN_PWR_BIT];
      inputFmt_next     = decodeFmt(inCtrl_reg[FMT_HI:0]);
      // DAC power ignores the output mute on purpose
      dacPower_next = pwrClk_reg[DAC_PWR_BIT];
      adcBias_next  = pwrClk_reg[ADC_BIAS_BIT];
      adcL_next     = pwrClk_reg[ADC_BIAS_BIT]
                      && pwrClk_reg[ADCL_PWR_BIT];
      adcR_next     = pwrClk_reg[ADC_BIAS_BIT]
                      && pwrClk_reg[ADCR_PWR_BIT];
      dacClk_next   = pwrClk_reg[DAC_CLK_BIT] && !autoGate;
      intMute_next  = autoGate;
      decClk_next   = pwrClk_reg[DEC_CLK_BIT];
      intClk_next   = pwrClk_reg[INT_CLK_BIT];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         outputMute_reg    <= 1'b0;
         outputPowerOn_reg <= 1'b1;
         outputSource_reg  <= SRC_IEC;
         outputFmt_reg     <= FMT_I2S;
         inputPowerOn_reg  <= 1'b1;
         inputFmt_reg      <= FMT_I2S;
         dacPower_reg      <= 1'b1;
         adcL_reg          <= 1'b1;
         adcR_reg          <= 1'b1;
         adcBias_reg       <= 1'b1;
         dacClk_reg        <= 1'b0;
         intMute_reg       <= 1'b0;
         decClk_reg        <= 1'b1;
         intClk_reg        <= 1'b1;
      end else begin
         outputMute_reg    <= outputMute_next;
         outputPowerOn_reg <= outputPowerOn_next;
         outputSource_reg  <= outputSource_next;
         outputFmt_reg     <= outputFmt_next;
         inputPowerOn_reg  <= inputPowerOn_next;
         inputFmt_reg      <= inputFmt_next;
         dacPower_reg      <= dacPower_next;
         adcL_reg          <= adcL_next;
         adcR_reg          <= adcR_next;
         adcBias_reg       <= adcBias_next;
         dacClk_reg        <= dacClk_next;
         intMute_reg       <= intMute_next;
         decClk_reg        <= decClk_next;
         intClk_reg        <= intClk_next;
      end
   end

   assign outputMute              = outputMute_reg;
   assign outputPowerOn           = outputPowerOn_reg;
   assign outputSource            = outputSource_reg;
   assign outputWordFormat        = outputFmt_reg;
   assign inputPowerOn            = inputPowerOn_reg;
   assign inputWordFormat         = inputFmt_reg;
   assign dacPowerOn              = dacPower_reg;
   assign leftAdcPowerOn          = adcL_reg;
   assign rightAdcPowerOn         = adcR_reg;
   assign adcBiasPowerOn          = adcBias_reg;
   assign dacClockEnable          = dacClk_reg;
   assign interpolatorMute        = intMute_reg;
   assign decimatorClockEnable    = decClk_reg;
   assign interpolatorClockEnable = intClk_reg;

   a_mute_follows: assert property (
      @(posedge clk) disable iff (!nrst)
      outputMute == $past(outCtrl_reg[OUT_MUTE_BIT]))
      else $error("output mute does not follow its bit");
   a_outpwr_follows: assert property (
      @(posedge clk) disable iff (!nrst)
      outputPowerOn == $past(outCtrl_reg[OUT_PWR_BIT]))
      else $error("output power does not follow its bit");
   a_src_select: assert property (
      @(posedge clk) disable iff (!nrst)
      sourceValid[selSrc] |=> outputSource == $past(selSrc))
      else $error("output source differs from selector");
   a_src_fallback: assert property (
      @(posedge clk) disable iff (!nrst)
      !sourceValid[selSrc] |=> outputSource == DEFAULT_SRC)
      else $error("invalid source not replaced by default");
   a_ofmt_unused: assert property (
      @(posedge clk) disable iff (!nrst)
      outCtrl_reg[2:1] == 2'h3 |=> outputWordFormat == DEFAULT_FMT)
      else $error("unused output format not defaulted");
   a_ifmt_decode: assert property (
      @(posedge clk) disable iff (!nrst)
      inCtrl_reg[2:0] <= 3'h5
      |=> inputWordFormat == $past(inCtrl_reg[2:0]))
      else $error("input format not decoded");
   a_inpwr_follows: assert property (
      @(posedge clk) disable iff (!nrst)
      inputPowerOn == $past(inCtrl_reg[IN_PWR_BIT]))
      else $error("input power does not follow its bit");
   a_adc_bias: assert property (
      @(posedge clk) disable iff (!nrst)
      !pwrClk_reg[ADC_BIAS_BIT] |=> !leftAdcPowerOn && !rightAdcPowerOn)
      else $error("ADC powered without bias");
   a_dac_autogate: assert property (
      @(posedge clk) disable iff (!nrst)
      autoGate |=> !dacClockEnable && interpolatorMute)
      else $error("DAC clock not gated on PLL unlock");
   a_reset_values: assert property (
      @(posedge clk)
      !nrst |=> outCtrl_reg == OUT_CTRL_RESET
      && inCtrl_reg == IN_CTRL_RESET
      && pwrClk_reg == PWR_CLK_RESET)
      else $error("register reset values wrong");
   a_bus_alive: assert property (
      @(posedge clk) disable iff (!nrst)
      arvalid && arready |=> rvalid)
      else $error("read not answered while paths are off");
endmodule : daio_regs
`default_nettype wire

// >>> daio_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module daio_regs_tb;
   import daio_pkg::*;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic [11:0]       awaddr = '0, araddr = '0;
   logic              awvalid = 0, wvalid = 0, bready = 0;
   logic              arvalid = 0, rready = 0;
   logic [31:0]       wdata = '0, rdata;
   logic [3:0]        wstrb = '0, sourceValid = 4'hF;
   logic              pllLocked = 1'b1;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp;
   logic              outputMute, outputPowerOn, inputPowerOn, dacPowerOn;
   logic              leftAdcPowerOn, rightAdcPowerOn, adcBiasPowerOn;
   logic              dacClockEnable, interpolatorMute;
   logic              decimatorClockEnable, interpolatorClockEnable;
   daio_src_t         outputSource;
   daio_fmt_t         outputWordFormat, inputWordFormat;
   int                fail_count = 0, n_checks = 0;
   integer            seed = 32'hf4ac97b9;
   logic [15:0]       mdl [3];
   logic [15:0]       msk [3] = '{OUT_CTRL_MASK, IN_CTRL_MASK, PWR_CLK_MASK};
   logic [11:0]       adr [3] = '{{IDX_OUT_CTRL, 2'b00}, {IDX_IN_CTRL, 2'b00},
                                  {IDX_PWR_CLK, 2'b00}};

   always #5 clk = ~clk;

   daio_regs dut_u (.clk(clk), .nrst(nrst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .sourceValid(sourceValid), .pllLocked(pllLocked),
      .outputMute(outputMute), .outputPowerOn(outputPowerOn),
      .outputSource(outputSource), .outputWordFormat(outputWordFormat),
      .inputPowerOn(inputPowerOn), .inputWordFormat(inputWordFormat),
      .dacPowerOn(dacPowerOn), .leftAdcPowerOn(leftAdcPowerOn),
      .rightAdcPowerOn(rightAdcPowerOn), .adcBiasPowerOn(adcBiasPowerOn),
      .dacClockEnable(dacClockEnable), .interpolatorMute(interpolatorMute),
      .decimatorClockEnable(decimatorClockEnable),
      .interpolatorClockEnable(interpolatorClockEnable));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, s);
         fail_count++;
      end
   endtask : chk

   // Address and data are released separately, each at its own handshake
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [1:0] r);
      int n;
      bit done;
      bit awHs, wHs;
      n = 0;
      done = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!done && n < 50) begin
         // Handshakes are judged on settled values, acted on after the edge
         @(negedge clk);
         awHs = awvalid && awready;
         wHs = wvalid && wready;
         done = bvalid && bready;
         if (done) r = bresp;
         @(posedge clk);
         if (awHs) awvalid <= 0;
         if (wHs) wvalid <= 0;
         if (done) bready <= 0;
         n++;
      end
      if (!done) fail_count++;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      bit done;
      bit arHs;
      n = 0;
      done = 0;
      @(posedge clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      while (!done && n < 50) begin
         @(negedge clk);
         arHs = arvalid && arready;
         done = rvalid && rready;
         if (done) begin
            d = rdata;
            r = rresp;
         end
         @(posedge clk);
         if (arHs) arvalid <= 0;
         if (done) rready <= 0;
         n++;
      end
      if (!done) fail_count++;
   endtask : axi_rd

   // Outputs lag the registers by one edge, so settle before comparing
   task automatic chk_outs;
      logic [1:0]  s;
      logic [2:0]  fo, fi;
      logic [15:0] p;
      logic [31:0] st;
      logic [1:0]  rs;
      logic        ag;
      repeat (2) @(posedge clk);
      #1;
      p = mdl[2];
      ag = p[6] & !pllLocked;
      s = mdl[0][5:4];
      if (!sourceValid[s]) s = 2'h2;
      fo = (mdl[0][2:0] > 3'h5) ? 3'h0 : mdl[0][2:0];
      fi = (mdl[1][2:0] > 3'h5) ? 3'h0 : mdl[1][2:0];
      chk("outs", {outputMute, outputPowerOn, outputSource, outputWordFormat},
          {mdl[0][8], mdl[0][7], s, fo});
      chk("ins", {inputPowerOn, inputWordFormat}, {mdl[1][7], fi});
      chk("pwr", {dacPowerOn, leftAdcPowerOn, rightAdcPowerOn, adcBiasPowerOn,
          decimatorClockEnable, interpolatorClockEnable}, {p[15], p[10] & p[8],
          p[9] & p[8], p[8], p[2], p[0]});
      chk("gate", {dacClockEnable, interpolatorMute},
          {p[7] & !(p[6] & !pllLocked), p[6] & !pllLocked});
      axi_rd({IDX_PATH_STATUS, 2'b00}, st, rs);
      chk("status resp", RESP_OKAY, rs);
      chk("status", {22'h0, s, ag, p[7] & !ag, ag, pllLocked, sourceValid},
          st);
   endtask : chk_outs

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [3:0]  s;
      int          k;
      mdl = '{16'h00A0, 16'h0080, 16'h8705};
      repeat (16) @(posedge clk);
      nrst <= 1;
      for (k = 0; k < 3; k++) begin
         axi_rd(adr[k], d, r);
         chk("reset value", {16'h0, mdl[k]}, d);
      end
      chk_outs();
      $display("test reset done");
      for (int i = 0; i < 36; i++) begin
         k = i % 3;
         // Reserved bits stay zero on writes
         d = $random(seed) & {16'h0, msk[k]};
         if (k < 2) d[2:0] = 3'((i / 3) % 8);
         if (k == 0) d[5:4] = 2'(i / 3);
         s = (i % 5 == 4) ? 4'($random(seed)) : 4'h3;
         @(posedge clk);
         sourceValid <= 4'($random(seed));
         pllLocked <= 1'($random(seed));
         axi_wr(adr[k], d, s, r);
         chk("write resp", RESP_OKAY, r);
         if (s[0]) mdl[k][7:0] = d[7:0];
         if (s[1]) mdl[k][15:8] = d[15:8];
         axi_rd(adr[k], d, r);
         chk("readback", {16'h0, mdl[k]}, d);
         chk_outs();
      end
      $display("test random writes done");
      axi_wr(12'h00C, 32'hFFFF, 4'hF, r);
      chk("unmapped write resp", RESP_SLVERR, r);
      axi_rd(12'h00C, d, r);
      chk("unmapped read resp", RESP_SLVERR, r);
      chk("unmapped read data", 32'h0, d);
      for (k = 0; k < 3; k++) begin
         axi_rd(adr[k], d, r);
         chk("after unmapped", {16'h0, mdl[k]}, d);
      end
      $display("test unmapped done");
      wrap_up();
   end

   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end
endmodule : daio_regs_tb
`default_nettype wire
